// ==== logic/lsr_top.sv ====
// lin slave unit: apb registers, receiver, transmitter and glue
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module lsr_top #(
  parameter logic [28:0] INACT_TICKS = 29'(lsr_pkg::INACT_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd
);
  typedef struct packed {
    logic [2:0] rxd_s;
    logic [2:0] div_cnt;
    logic [1:0] pre_cnt;
    logic [1:0] clk_div;
    logic fast;
    logic full_dis;
    logic to_en;
    logic rx_en;
    logic rx_act;
    logic [19:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_buf;
    logic f_sync;
    logic f_full;
    logic f_ovf;
    logic f_inact;
    logic f_err;
    logic tx_act;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [19:0] tx_cnt;
    logic txd;
    logic [19:0] baud;
    logic [31:0] prdata;
  } lsr_top_s;

  lsr_top_s q;
  lsr_top_s d;
  logic rxd_now;
  logic rxd_fall;
  logic rxd_rise;
  logic tick_sys;
  logic tick;
  logic sync_stb;
  logic [19:0] bit_per;
  logic expired;
  logic setup_rd;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  lsr_pkg::lsr_reg_e sel;
  logic [2:0] div_mask;
  logic [19:0] half;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == lsr_pkg::ADDR_CFG) || (a == lsr_pkg::ADDR_STAT) ||
              (a == lsr_pkg::ADDR_DATA) || (a == lsr_pkg::ADDR_BAUD);
  endfunction

  function automatic lsr_pkg::lsr_reg_e reg_of(input logic [11:0] a);
    reg_of = lsr_pkg::lsr_reg_e'(a[3:2]);
  endfunction

  assign mapped = reg_hit(paddr);
  assign sel = reg_of(paddr);
  assign acc = psel && penable && mapped;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = q.prdata;
  assign txd = q.txd;

  // ****************************************
  // line sampling and rate enables
  // ****************************************
  // first flop rxd_s[0] only feeds rxd_s[1]; rxd_s[2] is the previous level
  assign rxd_now = q.rxd_s[1];
  assign rxd_fall = q.rxd_s[2] && !q.rxd_s[1];
  assign rxd_rise = !q.rxd_s[2] && q.rxd_s[1];
  assign div_mask = 3'((4'h1 << q.clk_div) - 4'h1);
  assign tick_sys = (q.div_cnt & div_mask) == div_mask;
  // slow mode takes every fourth divided cycle: coarser timing, less toggling
  assign tick = tick_sys && (q.fast || q.pre_cnt == lsr_pkg::SLOW_PRE); // RQ2
  assign half = {1'b0, q.baud[19:1]};

  lsr_sync_detect u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .rxd_fall(rxd_fall),
    .rxd_rise(rxd_rise),
    .sync_stb(sync_stb),
    .bit_per(bit_per)
  );

  lsr_inact_timer #(
    .LIMIT(INACT_TICKS)
  ) u_inact (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_sys),
    .enable(q.to_en),
    .rxd_edge(rxd_fall || rxd_rise),
    .expired(expired)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.rxd_s = {q.rxd_s[1:0], rxd};
    d.div_cnt = q.div_cnt + 3'h1;
    if (tick_sys) d.pre_cnt = q.pre_cnt + 2'h1;

    // bus reads and their side effects
    if (setup_rd) begin
      unique case (reg_of(paddr))
        lsr_pkg::LSR_R_CFG: begin
          d.prdata = '0;
          d.prdata[lsr_pkg::CFG_FDIS] = q.full_dis;
          d.prdata[lsr_pkg::CFG_TOEN] = q.to_en;
          d.prdata[lsr_pkg::CFG_FAST] = q.fast;
          d.prdata[lsr_pkg::CFG_DIV +: 2] = q.clk_div;
          d.prdata[lsr_pkg::CFG_RECEIVER_ENABLE] = q.rx_en;
          d.prdata[lsr_pkg::CFG_RXACT] = q.rx_act;
          d.prdata[lsr_pkg::CFG_TXACT] = q.tx_act;
        end
        lsr_pkg::LSR_R_STAT: begin
          d.prdata = '0;
          d.prdata[lsr_pkg::ST_SYNC] = q.f_sync;
          d.prdata[lsr_pkg::ST_FULL] = q.f_full;
          d.prdata[lsr_pkg::ST_OVF] = q.f_ovf;
          d.prdata[lsr_pkg::ST_INACT] = q.f_inact;
          d.prdata[lsr_pkg::ST_TXEMPTY] = !q.tx_act;
          d.prdata[lsr_pkg::ST_ERR] = q.f_err;
        end
        lsr_pkg::LSR_R_DATA: d.prdata = {24'h0, q.rx_buf};
        lsr_pkg::LSR_R_BAUD: d.prdata = {12'h0, q.baud};
      endcase
      if (!mapped) d.prdata = '0;
    end
    if (rd && sel == lsr_pkg::LSR_R_DATA) d.f_full = 1'b0;

    // bus writes; flag clears come before hardware sets so a set wins
    if (wr) begin
      unique case (sel)
        lsr_pkg::LSR_R_CFG: begin
          d.full_dis = pwdata[lsr_pkg::CFG_FDIS];
          d.to_en = pwdata[lsr_pkg::CFG_TOEN]; // RQ5
          d.fast = pwdata[lsr_pkg::CFG_FAST];
          d.clk_div = pwdata[lsr_pkg::CFG_DIV +: 2];
          if (pwdata[lsr_pkg::CFG_STOP]) begin // RQ18
            d.rx_en = 1'b0;
            d.rx_act = 1'b0;
            d.rx_bit = '0;
            d.rx_cnt = '0;
          end
        end
        lsr_pkg::LSR_R_STAT: begin
          if (pwdata[lsr_pkg::ST_SYNC]) d.f_sync = 1'b0;
          if (pwdata[lsr_pkg::ST_OVF]) d.f_ovf = 1'b0;
          if (pwdata[lsr_pkg::ST_INACT]) d.f_inact = 1'b0;
          if (pwdata[lsr_pkg::ST_ERR]) d.f_err = 1'b0;
        end
        lsr_pkg::LSR_R_DATA: begin
          // no transmit buffer: a write during a transmission is dropped
          if (!q.tx_act) begin // RQ20
            d.tx_act = 1'b1;
            d.tx_sh = {pwdata[7:0], 1'b0, 1'b1}; // RQ7
            d.tx_bit = '0;
            d.tx_cnt = q.baud - 20'h1;
            d.rx_en = 1'b0;
            d.rx_act = 1'b0;
            if (q.rx_act) begin
              d.tx_act = 1'b0;
              d.f_err = 1'b1;
            end
          end
        end
        lsr_pkg::LSR_R_BAUD: begin
          if (q.full_dis) d.baud = pwdata[19:0]; // RQ24
        end
      endcase
    end

    // ****************************************
    // receiver
    // ****************************************
    if (q.rx_en && !q.rx_act && rxd_fall) begin // RQ13
      d.rx_act = 1'b1;
      d.rx_bit = '0;
      d.rx_cnt = q.baud + half - 20'h1; // RQ8
    end else if (q.rx_act && tick) begin
      if (q.rx_cnt != '0) begin
        d.rx_cnt = q.rx_cnt - 20'h1;
      end else if (q.rx_bit == lsr_pkg::STOP_BIT) begin
        d.rx_act = 1'b0; // RQ14
        if (rxd_now) begin
          if (!q.f_full || (rd && sel == lsr_pkg::LSR_R_DATA)) begin // RQ15
            d.rx_buf = q.rx_sh;
            d.f_full = 1'b1;
          end else begin
            d.f_ovf = 1'b1;
          end
        end else begin
          d.rx_en = 1'b0; // RQ16
        end
      end else begin
        d.rx_sh = {rxd_now, q.rx_sh[7:1]}; // RQ8
        d.rx_bit = q.rx_bit + 4'h1;
        d.rx_cnt = q.baud - 20'h1;
      end
    end

    // ****************************************
    // transmitter
    // ****************************************
    if (q.tx_act && tick) begin
      if (q.tx_cnt != '0) begin
        d.tx_cnt = q.tx_cnt - 20'h1;
      end else if (rxd_now != q.tx_sh[0]) begin // RQ9
        d.tx_act = 1'b0;
        d.f_err = 1'b1;
      end else if (q.tx_bit == lsr_pkg::TX_LAST) begin
        d.tx_act = 1'b0;
      end else begin
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_bit = q.tx_bit + 4'h1;
        d.tx_cnt = q.baud - 20'h1;
      end
    end

    // ****************************************
    // hardware events with final say
    // ****************************************
    if (expired) d.f_inact = 1'b1; // RQ3
    if (sync_stb) begin // RQ6
      d.baud = bit_per; // RQ10
      d.rx_en = !q.full_dis; // RQ19
      d.rx_act = 1'b0; // RQ12
      d.rx_bit = '0;
      d.rx_cnt = '0;
      d.f_sync = 1'b1; // RQ11
      d.tx_act = 1'b0; // RQ23
    end
    if (d.full_dis) begin // RQ21
      d.rx_en = 1'b0;
      d.rx_act = 1'b0;
    end
    d.txd = d.tx_act ? d.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.rxd_s <= 3'h7;
      q.full_dis <= lsr_pkg::RST_FDIS;
      q.to_en <= lsr_pkg::RST_TOEN;
      q.rx_en <= lsr_pkg::RST_RECEIVER_ENABLE;
      q.fast <= 1'b1;
      q.baud <= 20'h00010;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sync_enables_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    sync_stb && !q.full_dis && !(wr && sel == lsr_pkg::LSR_R_CFG)
    |=> q.rx_en && !q.rx_act && q.baud == $past(bit_per))
    else $error("sync did not enable idle receiver");
  sync_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    sync_stb |=> q.f_sync ##1 (q.f_sync || $past(wr && sel == lsr_pkg::LSR_R_STAT)))
    else $error("sync flag not sticky");
  stop_rx_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    wr && sel == lsr_pkg::LSR_R_CFG && pwdata[lsr_pkg::CFG_STOP] && !sync_stb
    |=> !q.rx_en && !q.rx_act)
    else $error("stop strobe left receiver on");
  tx_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
    wr && sel == lsr_pkg::LSR_R_DATA && !q.tx_act && !q.rx_act && !sync_stb
    |=> q.tx_act && !q.rx_en && q.txd)
    else $error("transmit write did not swap direction");
  tx_stop_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ23
    sync_stb |=> !q.tx_act && q.txd)
    else $error("sync did not stop transmitter");
  rx_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    $rose(q.rx_act) |-> $past(rxd_fall) && $past(q.rx_en))
    else $error("receiver started without falling edge");
  overflow_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    q.rx_act && tick && q.rx_cnt == '0 && q.rx_bit == lsr_pkg::STOP_BIT && rxd_now &&
    q.f_full && !rd && !sync_stb
    |=> q.f_ovf && q.rx_buf == $past(q.rx_buf))
    else $error("overflow not flagged or buffer overwritten");
  bad_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    q.rx_act && tick && q.rx_cnt == '0 && q.rx_bit == lsr_pkg::STOP_BIT && !rxd_now &&
    !sync_stb
    |=> !q.rx_en && !q.rx_act && $stable(q.rx_buf))
    else $error("low stop bit not handled");
  stays_enabled_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    $fell(q.rx_act) && $past(rxd_now) && !$past(wr) && !$past(sync_stb) |-> q.rx_en)
    else $error("receiver disabled after good byte");
  full_dis_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    q.full_dis && sync_stb |=> !q.rx_en)
    else $error("full disable overridden by sync");
endmodule

// ==== logic/lsr_pkg.sv ====
// constants, field layout and state codes of the lin slave receive unit
// How it works
// RQ1: sync strobe on stop-bit rising edge, baud updated
// RQ2: slow mode to 30k, fast mode per divider
// RQ3: inactivity over 4 s raises timeout flag
// RQ4: timer restarts on any edge, counts until expiry
// RQ5: timeout_counter_enable clear switches timer off
// RQ6: new break plus sync aborts any transaction
// RQ7: byte is start, eight data, stop
// RQ8: align on start fall, sample mid-bit
// RQ9: transmitter compares read-back with each sent bit
// RQ10: sync loads baud, enables, idles receiver
// RQ11: sync sets sticky sync_detected until cleared
// RQ12: sync during reception discards partial byte
// RQ13: enabled idle receiver starts on falling edge
// RQ14: receiver goes inactive at stop-bit middle
// RQ15: good stop stores byte, else overflow flag
// RQ16: low stop stores nothing, disables receiver
// RQ17: after a byte receiver stays enabled, idle
// RQ18: stop_receiver strobe clears enable and active
// RQ19: next sync re-enables a stopped receiver
// RQ20: transmit write disables receiver, starts transmitter; with the receiver active the code sets the error flag instead
// RQ21: receiver_full_disable keeps receiver off despite sync
// RQ22: software disables receiver and timer before clock changes
// RQ23: sync during transmit stops the transmitter
// RQ24: software leaves baud alone unless fully disabled
// RQ25: bit period timed from sync field edges
package lsr_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned INACT_TIME_MS = 4000;
  // one more than the limit, so expiry means strictly more than the time
  localparam int unsigned INACT_CYCLES = CLK_HZ / 1000 * INACT_TIME_MS + 1;
  localparam int unsigned INACT_W = 29;
  localparam int unsigned CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_MAX = 20'hFFFFF;
  localparam logic [CNT_W-1:0] SYNC_MIN = 20'h00010;
  localparam logic [1:0] SLOW_PRE = 2'h3;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_BAUD = 12'h00C;
  localparam int unsigned CFG_STOP = 0;
  localparam int unsigned CFG_FDIS = 1;
  localparam int unsigned CFG_TOEN = 2;
  localparam int unsigned CFG_FAST = 3;
  localparam int unsigned CFG_DIV = 4;
  localparam int unsigned CFG_RECEIVER_ENABLE = 6;
  localparam int unsigned CFG_RXACT = 7;
  localparam int unsigned CFG_TXACT = 8;
  localparam int unsigned ST_SYNC = 0;
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_OVF = 2;
  localparam int unsigned ST_INACT = 3;
  localparam int unsigned ST_TXEMPTY = 4;
  localparam int unsigned ST_ERR = 5;
  localparam logic RST_FDIS = 1'b0;
  localparam logic RST_TOEN = 1'b0;
  localparam logic RST_RECEIVER_ENABLE = 1'b1;
  localparam logic [3:0] STOP_BIT = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h9;
  localparam logic [2:0] SYNC_FALLS = 3'h4;
  typedef enum logic [1:0] {
    LSR_R_CFG = 2'b00, LSR_R_STAT = 2'b01, LSR_R_DATA = 2'b10, LSR_R_BAUD = 2'b11
  } lsr_reg_e;
  typedef enum logic [2:0] {
    LSR_SD_IDLE = 3'b000, LSR_SD_BRK = 3'b001, LSR_SD_DEL = 3'b010,
    LSR_SD_SYN = 3'b011, LSR_SD_STP = 3'b100
  } lsr_sd_e;
endpackage

// ==== logic/lsr_sync_detect.sv ====
// break plus sync field detector with bit period measurement
`timescale 1ns/1ps
module lsr_sync_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic rxd_fall,
  input wire logic rxd_rise,
  output logic sync_stb,
  output logic [19:0] bit_per
);
  typedef struct packed {
    lsr_pkg::lsr_sd_e st;
    logic [19:0] cnt;
    logic [19:0] brk;
    logic [19:0] per;
    logic [2:0] nfall;
    logic stb;
    logic [19:0] low;
    logic lo;
  } lsr_sd_s;
  lsr_sd_s q;
  lsr_sd_s d;
  logic [21:0] need;

  // a break must last at least eleven bits: 8 bits plus 3/8 of them
  always_comb begin
    need = {2'h0, q.cnt} + {4'h0, q.cnt[19:2]} + {5'h0, q.cnt[19:3]};
    d = q;
    d.stb = 1'b0;
    // length of the present low, kept in every state so a long low can turn into a break
    if (rxd_fall) begin
      d.lo = 1'b1;
      d.low = '0;
    end else if (rxd_rise) begin
      d.lo = 1'b0;
    end else if (q.lo && tick && q.low != lsr_pkg::CNT_MAX) begin
      d.low = q.low + 20'h1;
    end
    unique case (q.st)
      lsr_pkg::LSR_SD_IDLE: begin
        if (rxd_fall) begin
          d.st = lsr_pkg::LSR_SD_BRK;
          d.cnt = '0;
        end
      end
      lsr_pkg::LSR_SD_BRK: begin
        if (tick && q.cnt != lsr_pkg::CNT_MAX) d.cnt = q.cnt + 20'h1;
        if (rxd_rise) begin
          d.brk = q.cnt;
          d.st = lsr_pkg::LSR_SD_DEL;
        end
      end
      lsr_pkg::LSR_SD_DEL: begin
        if (rxd_fall) begin
          d.st = lsr_pkg::LSR_SD_SYN;
          // the tick of the start-fall cycle counts too, so eight bits give eight periods
          d.cnt = {19'h0, tick};
          d.nfall = 3'h1;
        end
      end
      lsr_pkg::LSR_SD_SYN: begin
        if (q.lo && q.low > {2'h0, q.brk[19:2]}) begin // RQ6
          // far too long a low for a sync bit: a break is under way, keep timing it
          d.st = lsr_pkg::LSR_SD_BRK;
          d.cnt = q.low;
          if (rxd_rise) begin
            d.st = lsr_pkg::LSR_SD_DEL;
            d.brk = q.low;
          end
        end else begin
          if (tick) begin
            if (q.cnt == lsr_pkg::CNT_MAX) d.st = lsr_pkg::LSR_SD_IDLE;
            else d.cnt = q.cnt + 20'h1;
          end
          // five falling edges of 0x55 span exactly eight bits
          if (rxd_fall) begin // RQ25
            if (q.nfall == lsr_pkg::SYNC_FALLS) begin
              if ({2'h0, q.brk} >= need && q.cnt >= lsr_pkg::SYNC_MIN) begin
                d.per = {3'h0, q.cnt[19:3]};
                d.st = lsr_pkg::LSR_SD_STP;
              end else begin
                // this fall may open a real break, so start timing it at once
                d.st = lsr_pkg::LSR_SD_BRK;
                d.cnt = '0;
              end
            end else begin
              d.nfall = q.nfall + 3'h1;
            end
          end
        end
      end
      lsr_pkg::LSR_SD_STP: begin
        if (rxd_rise) begin // RQ1
          d.stb = 1'b1;
          d.st = lsr_pkg::LSR_SD_IDLE;
        end else if (rxd_fall) begin
          d.st = lsr_pkg::LSR_SD_IDLE;
        end
      end
      default: d.st = lsr_pkg::LSR_SD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_stb = q.stb;
  assign bit_per = q.per;

  stb_after_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    q.stb |-> $past(rxd_rise) && $past(q.st) == lsr_pkg::LSR_SD_STP)
    else $error("sync strobe without stop-bit rising edge");
  per_nonzero_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ25
    q.stb |-> q.per >= 20'h2)
    else $error("sync strobe with too short a bit period");
endmodule

// ==== logic/lsr_inact_timer.sv ====
// bus inactivity timer
`timescale 1ns/1ps
module lsr_inact_timer #(
  parameter logic [28:0] LIMIT = 29'(lsr_pkg::INACT_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic rxd_edge,
  output logic expired
);
  typedef struct packed {
    logic [28:0] cnt;
    logic hit;
  } lsr_it_s;
  lsr_it_s q;
  lsr_it_s d;

  always_comb begin
    d = q;
    d.hit = 1'b0;
    if (!enable) begin // RQ5
      d.cnt = '0;
    end else if (rxd_edge) begin // RQ4
      d.cnt = '0;
    end else if (tick && q.cnt != LIMIT) begin // RQ4
      d.cnt = q.cnt + 29'h1;
      d.hit = (q.cnt == LIMIT - 29'h1); // RQ3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.hit;

  edge_restart_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    rxd_edge |=> q.cnt == '0)
    else $error("timer not restarted by bus edge");
  expire_once_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    q.hit |-> q.cnt == LIMIT && $past(q.cnt) == LIMIT - 29'h1)
    else $error("timeout raised at wrong count");
  off_clears_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    !enable |=> q.cnt == '0 && !q.hit)
    else $error("disabled timer still counting");
endmodule

// ==== test/lsr_lin_master.sv ====
// lin master model driving the shared bus line
`timescale 1ns/1ps
module lsr_lin_master #(
  parameter int BIT = 40
) (
  input wire logic pclk,
  output logic line
);
  // **********
  // bus driving
  // **********
  // bus has a pull-up, so an idle master leaves it high
  initial line = 1'h1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge pclk);
  endtask
  // start low, eight data lsb first, stop, then one idle bit
  task automatic send_byte(input logic [7:0] b, input logic stp);
    hold(1'h0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT);
    end
    hold(stp, BIT);
    hold(1'h1, BIT);
  endtask
  // break of 13 bit times, delimiter, then the sync byte
  task automatic send_header();
    hold(1'h0, 13 * BIT);
    hold(1'h1, BIT);
    send_byte(8'h55, 1'h1);
  endtask
endmodule

// ==== test/lsr_top_tb.sv ====
// self-checking bench of the lin slave receive unit
`timescale 1ns/1ps
module lsr_top_tb;
  localparam int BIT = 40;
  localparam logic [11:0] CFG = lsr_pkg::ADDR_CFG;
  localparam logic [11:0] STAT = lsr_pkg::ADDR_STAT;
  localparam logic [11:0] DATA = lsr_pkg::ADDR_DATA;
  localparam logic [11:0] BAUD = lsr_pkg::ADDR_BAUD;
  typedef struct {logic [31:0] e; logic [31:0] m; logic er;} lsr_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, line, rxd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] b0, b1;
  int errors, checked, test_no;
  lsr_note_s notes[$];
  lsr_note_s n;
  // wired-and bus: dominant low from either party
  assign rxd = line & txd;
  lsr_top #(.INACT_TICKS(29'h0C8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
  lsr_lin_master #(.BIT(BIT)) mdl_u (.pclk(pclk), .line(line));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // **********
  // bus tasks
  // **********
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic er = 1'h0);
    notes.push_back('{e, m, er});
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic wait_c(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic done();
    $display("test %0d done", test_no);
    test_no++;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // **********
  // result watcher
  // **********
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      checked++;
      if (((prdata & n.m) !== n.e) || (pslverr !== n.er)) begin
        errors++;
        $display("unexpected read %h: expected %h/%b seen %h/%b", paddr, n.e, n.er,
          prdata & n.m, pslverr);
      end
    end
  end
  // a hang counts as a mismatch
  initial begin
    wait_c(40000);
    errors++;
    give_verdict();
  end
  // **********
  // tests
  // **********
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    checked = 0;
    test_no = 1;
    b0 = 8'($urandom(32'h432EF2EF));
    b1 = 8'($urandom);
    wait_c(16);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(CFG, 32'h48, 32'h1FF);
    rd(STAT, 32'h10, 32'h3F);
    rd(BAUD, 32'h10, 32'hFFFFF);
    rd(12'h010, 32'h0, 32'hFFFFFFFF, 1'h1);
    done();
    // divider untouched here, so the receiver may stay on
    wr(CFG, 32'h8);
    wait_c(250);
    rd(STAT, 32'h0, 32'h8);
    wr(CFG, 32'hC);
    wait_c(250);
    rd(STAT, 32'h8, 32'h8);
    wr(CFG, 32'h8);
    wr(STAT, 32'h8);
    rd(STAT, 32'h0, 32'h8);
    done();
    // break starts a byte whose low stop bit drops it and turns the receiver off until the sync
    mdl_u.send_header();
    rd(STAT, 32'h1, 32'h3);
    rd(BAUD, BIT, 32'hFFFFF);
    rd(CFG, 32'h48, 32'h1C8);
    wr(CFG, 32'hC);
    mdl_u.send_byte(8'h55, 1'h1);
    rd(STAT, 32'h3, 32'hF);
    wr(CFG, 32'h8);
    wr(STAT, 32'h1);
    rd(DATA, 32'h55, 32'hFF);
    rd(STAT, 32'h0, 32'h3);
    done();
    fork
      mdl_u.send_byte(b0, 1'h1);
      begin
        wait_c(100);
        rd(CFG, 32'hC0, 32'hC0);
      end
    join
    rd(CFG, 32'h40, 32'hC0);
    rd(DATA, {24'h0, b0}, 32'hFF);
    mdl_u.send_byte(b1, 1'h1);
    mdl_u.send_byte(~b1, 1'h1);
    rd(STAT, 32'h6, 32'h6);
    rd(DATA, {24'h0, b1}, 32'hFF);
    wr(STAT, 32'h4);
    done();
    mdl_u.send_byte(b0, 1'h0);
    rd(CFG, 32'h0, 32'hC0);
    mdl_u.send_byte(b1, 1'h1);
    rd(STAT, 32'h0, 32'h2);
    mdl_u.send_header();
    rd(CFG, 32'h40, 32'hC1);
    wr(CFG, 32'h9);
    rd(CFG, 32'h0, 32'hC1);
    mdl_u.send_byte(b0, 1'h1);
    rd(STAT, 32'h0, 32'h2);
    mdl_u.send_header();
    rd(CFG, 32'h40, 32'hC0);
    done();
    wr(CFG, 32'hA);
    mdl_u.send_header();
    rd(CFG, 32'h0, 32'h40);
    wr(CFG, 32'h8);
    mdl_u.send_header();
    rd(CFG, 32'h40, 32'hC0);
    done();
    wr(DATA, 32'hA5);
    rd(CFG, 32'h100, 32'h1C0);
    wait_c(600);
    rd(STAT, 32'h10, 32'h30);
    // bus held low by the master makes the next send a conflict
    mdl_u.send_header();
    mdl_u.hold(1'h0, 5);
    wr(DATA, 32'h5A);
    mdl_u.hold(1'h1, 600);
    rd(STAT, 32'h30, 32'h30);
    rd(CFG, 32'h0, 32'h100);
    done();
    // master pulls a recessive data bit low: read-back must stop the send
    wr(STAT, 32'h20);
    wr(DATA, 32'hFF);
    mdl_u.hold(1'h1, 100);
    mdl_u.hold(1'h0, 40);
    mdl_u.hold(1'h1, 200);
    rd(STAT, 32'h30, 32'h30);
    rd(CFG, 32'h0, 32'h100);
    done();
    // slow mode at divider 1 (divide by 2), set up with receiver and timer fully off
    wr(CFG, 32'h2);
    wr(CFG, 32'h12);
    wr(CFG, 32'h10);
    mdl_u.send_header();
    rd(BAUD, 32'h5, 32'hFFFFF);
    mdl_u.send_byte(b1, 1'h1);
    rd(DATA, {24'h0, b1}, 32'hFF);
    done();
    give_verdict();
  end
endmodule
